// [src/lgt_pin_bit.sv]
// one pin's routed data path: optional output pipeline and input double synchroniser
// assumes the system clock and an already synchronised active-low reset
`timescale 1ns/1ns
module lgt_pin_bit
   import lgt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic out_sync_en,
   input wire logic in_sync_en,
   input wire logic rt_out,
   input wire logic pin_in,
   output logic pin_out,
   output logic rt_in
);
   logic out_pipe_reg;
   logic in_meta_reg;
   logic in_sync_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_pipe_reg <= 1'b0;
         in_meta_reg <= 1'b0;
         in_sync_reg <= 1'b0;
      end else begin
         out_pipe_reg <= rt_out;
         in_meta_reg <= pin_in;
         in_sync_reg <= in_meta_reg;
      end
   end

   assign pin_out = out_sync_en ? out_pipe_reg : rt_out;
   // unsynchronised path serves combinational feedthrough only
   assign rt_in = in_sync_en ? in_sync_reg : pin_in;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_out_pipe: assert property (out_sync_en [*2] |-> pin_out == $past(rt_out))
      else $error("piped pin output not one cycle behind routed data");
   a_out_pass: assert property (!out_sync_en |-> pin_out == rt_out)
      else $error("unpiped pin output differs from routed data");
   a_in_sync: assert property (in_sync_en [*3] |-> rt_in == $past(pin_in, 2))
      else $error("synchronised pin input not two cycles behind pin");
   c_in_sync: cover property (in_sync_en [*3] ##0 $rose(rt_in));
endmodule

// [src/lgt_pkg.sv]
// shared types and constants for the logic tile datapath, status/control and pin stage
// assumes one system clock; all routed signals arrive synchronous to it
package lgt_pkg;

   localparam int LGT_DW = 8;
   localparam int LGT_CFG_DEPTH = 8;
   localparam int LGT_CFG_AW = 3;
   localparam int LGT_RT_N = 6;
   localparam int LGT_PIN_N = 8;
   localparam int LGT_DRV_N = 4;
   localparam int LGT_STS_N = 8;
   localparam int LGT_OSRC_W = 3;
   localparam int LGT_SSRC_W = 4;

   localparam logic [7:0] LGT_CTL_RESET = 8'h00;
   localparam logic [7:0] LGT_STS_RESET = 8'h00;
   localparam logic [7:0] LGT_ACC_RESET = 8'h00;
   localparam logic [5:0] LGT_RT_RESET = 6'h00;
   localparam logic [3:0] LGT_DRV_RESET = 4'h0;
   localparam logic [1:0] LGT_COND_RESET = 2'h0;

   typedef enum logic [2:0] {
      LGT_OP_INC = 3'h0,
      LGT_OP_DEC = 3'h1,
      LGT_OP_ADD = 3'h2,
      LGT_OP_SUB = 3'h3,
      LGT_OP_AND = 3'h4,
      LGT_OP_OR = 3'h5,
      LGT_OP_XOR = 3'h6,
      LGT_OP_PASS = 3'h7
   } lgt_op_e;

   typedef enum logic [1:0] {
      LGT_SH_NONE = 2'h0,
      LGT_SH_LEFT = 2'h1,
      LGT_SH_RIGHT = 2'h2,
      LGT_SH_SWAP = 2'h3
   } lgt_shift_e;

   typedef enum logic [1:0] {
      LGT_CIN_ZERO = 2'h0,
      LGT_CIN_ROUTED = 2'h1,
      LGT_CIN_CHAIN = 2'h2,
      LGT_CIN_REG = 2'h3
   } lgt_cin_e;

   typedef enum logic [1:0] {
      LGT_SIN_ROUTED = 2'h0,
      LGT_SIN_CHAIN = 2'h1,
      LGT_SIN_REG = 2'h2,
      LGT_SIN_ZERO = 2'h3
   } lgt_sin_e;

   typedef enum logic [1:0] {
      LGT_RUN_ALWAYS = 2'h0,
      LGT_RUN_CTL = 2'h1,
      LGT_RUN_OFF = 2'h2,
      LGT_RUN_EXT = 2'h3
   } lgt_run_e;

   // one configuration memory word
   typedef struct packed {
      logic [3:0] spare;
      logic chain_eq;
      logic acc_we;
      lgt_sin_e sin_sel;
      lgt_cin_e cin_sel;
      logic reg_set;
      lgt_shift_e shift;
      lgt_op_e op;
   } lgt_cfg_s;

   // six routed datapath inputs
   typedef struct packed {
      logic ce;
      logic cin;
      logic sin;
      logic [2:0] cfg_addr;
   } lgt_rtin_s;

   // sources selectable onto each routed datapath output
   typedef struct packed {
      logic carry;
      logic sout;
      logic ones1;
      logic zero1;
      logic eq1;
      logic ones0;
      logic zero0;
      logic eq0;
   } lgt_osrc_s;

   typedef struct packed {
      logic [7:0] out_sync;
      logic [7:0] in_sync;
   } lgt_pin_cfg_s;

endpackage

// [src/lgt_tile.sv]
// logic tile datapath with time multiplexing, status/control unit and pin stage
// assumes routed inputs synchronous to SYS_CLK and firmware access as plain strobes
//
// Overview of operation
// - carry, shift, compare chain to neighbour datapaths
// - carry/shift out registered, selectable next cycle
// - 8-bit datapath does 16-bit work in halves
// - six routed inputs and six routed outputs
// - routed inputs pick operation and serial data
// - each output selects condition or serial out
// - control register bits drive the routing
// - status register read-only, shows routed state
// - every status/control bit individually routable
// - sticky status captures pulse, cleared by read
// - control bit usable as block enable
// - datapath and status/control each have own enable selection
// - port has sixteen data, four drive routes
// - pin output optionally one register stage
// - pin input optionally two-stage synchronised
// - eight-by-sixteen configuration memory, routed address
`timescale 1ns/1ns
module lgt_tile
   import lgt_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CFG_WE,
   input wire logic [LGT_CFG_AW-1:0] CFG_WADDR,
   input wire lgt_cfg_s CFG_WDATA,
   input wire logic DREG_WE,
   input wire logic DREG_SEL,
   input wire logic [LGT_DW-1:0] DREG_WDATA,
   input wire lgt_rtin_s RT_IN,
   input wire logic [LGT_RT_N-1:0][LGT_OSRC_W-1:0] OUT_SEL,
   output logic [LGT_RT_N-1:0] RT_OUT,
   output logic [LGT_DW-1:0] ACC0,
   output logic [LGT_DW-1:0] ACC1,
   input wire logic CHAIN_CI,
   input wire logic CHAIN_SI,
   input wire logic CHAIN_EQ_IN,
   output logic CHAIN_CO,
   output logic CHAIN_SO,
   output logic CHAIN_EQ_OUT,
   input wire lgt_run_e DP_RUN_SEL,
   input wire lgt_run_e SC_RUN_SEL,
   input wire logic [2:0] CE_BIT_SEL,
   input wire logic SC_EXT_CE,
   input wire logic CTL_WE,
   input wire logic [LGT_STS_N-1:0] CTL_WDATA,
   input wire logic [LGT_STS_N-1:0] CTL_ROUTE_EN,
   output logic [LGT_STS_N-1:0] CTL_RT_OUT,
   input wire logic [1:0] STS_RT_IN,
   input wire logic [LGT_STS_N-1:0][LGT_SSRC_W-1:0] STS_SEL,
   input wire logic [LGT_STS_N-1:0] STS_STICKY,
   input wire logic STS_RD,
   output logic [LGT_STS_N-1:0] STS_RDATA,
   input wire lgt_pin_cfg_s PIN_CFG,
   input wire logic [LGT_PIN_N-1:0] PIN_RT_OUT,
   input wire logic [LGT_PIN_N-1:0] PIN_IN,
   output logic [LGT_PIN_N-1:0] PIN_OUT,
   output logic [LGT_PIN_N-1:0] PIN_RT_IN,
   input wire logic [LGT_DRV_N-1:0] DRV_RT,
   output logic [LGT_DRV_N-1:0] PIN_DRV
);
   logic rst_meta_reg;
   logic rst_n_reg;
   lgt_cfg_s cfg_mem [LGT_CFG_DEPTH];
   lgt_cfg_s cfg;
   logic [LGT_DW-1:0] acc0_reg, acc1_reg, d0_reg, d1_reg;
   logic carry_reg, sout_reg;
   logic [1:0] eq_reg, zero_reg, ones_reg;
   logic [LGT_RT_N-1:0] rt_out_reg;
   logic [LGT_STS_N-1:0] ctl_reg, hold_reg, sts_rdata_reg;
   logic [LGT_DRV_N-1:0] drv_reg;
   logic [LGT_DW-1:0] a_val, d_val, sh_val;
   logic [LGT_DW:0] sum;
   logic cin, sin, sout, eq_now;
   logic dp_run, sc_run;
   lgt_osrc_s osrc;
   logic [LGT_RT_N-1:0] rt_out_next;
   logic [15:0] sts_src;
   logic [LGT_STS_N-1:0] sts_live, sts_set, hold_next, sts_view;

   // reset release through two flops
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   function automatic logic run_en(lgt_run_e s, logic [7:0] c, logic [2:0] b, logic e);
      case (s)
         LGT_RUN_ALWAYS: run_en = 1'b1;
         LGT_RUN_CTL: run_en = c[b];
         LGT_RUN_OFF: run_en = 1'b0;
         LGT_RUN_EXT: run_en = e;
         default: run_en = 1'b0;
      endcase
   endfunction

   // independent enables for datapath and status/control
   assign dp_run = run_en(DP_RUN_SEL, ctl_reg, CE_BIT_SEL, RT_IN.ce);
   assign sc_run = run_en(SC_RUN_SEL, ctl_reg, CE_BIT_SEL, SC_EXT_CE);

   // configuration memory addressed by the routed inputs
   always_ff @(posedge SYS_CLK) begin
      if (CFG_WE) begin
         cfg_mem[CFG_WADDR] <= CFG_WDATA;
      end
   end
   assign cfg = cfg_mem[RT_IN.cfg_addr];

   // register set chosen per cycle lets one ALU serve two halves
   assign a_val = cfg.reg_set ? acc1_reg : acc0_reg;
   assign d_val = cfg.reg_set ? d1_reg : d0_reg;
   assign cin = (cfg.cin_sel == LGT_CIN_ROUTED) ? RT_IN.cin :
                (cfg.cin_sel == LGT_CIN_CHAIN) ? CHAIN_CI :
                (cfg.cin_sel == LGT_CIN_REG) ? carry_reg : 1'b0;
   assign sin = (cfg.sin_sel == LGT_SIN_ROUTED) ? RT_IN.sin :
                (cfg.sin_sel == LGT_SIN_CHAIN) ? CHAIN_SI :
                (cfg.sin_sel == LGT_SIN_REG) ? sout_reg : 1'b0;

   always_comb begin
      case (cfg.op)
         LGT_OP_INC: sum = {1'b0, a_val} + 9'h001;
         LGT_OP_DEC: sum = {1'b0, a_val} - 9'h001;
         LGT_OP_ADD: sum = {1'b0, a_val} + {1'b0, d_val} + {8'h00, cin};
         LGT_OP_SUB: sum = {1'b0, a_val} + {1'b0, ~d_val} + {8'h00, cin};
         LGT_OP_AND: sum = {1'b0, a_val & d_val};
         LGT_OP_OR: sum = {1'b0, a_val | d_val};
         LGT_OP_XOR: sum = {1'b0, a_val ^ d_val};
         LGT_OP_PASS: sum = {1'b0, a_val};
         default: sum = 9'h000;
      endcase
      case (cfg.shift)
         LGT_SH_LEFT: begin
            sh_val = {sum[6:0], sin};
            sout = sum[7];
         end
         LGT_SH_RIGHT: begin
            sh_val = {sin, sum[7:1]};
            sout = sum[0];
         end
         LGT_SH_SWAP: begin
            sh_val = {sum[3:0], sum[7:4]};
            sout = 1'b0;
         end
         default: begin
            sh_val = sum[7:0];
            sout = 1'b0;
         end
      endcase
   end

   // compare chains with the neighbour below when asked
   assign eq_now = (a_val == d_val) & (cfg.chain_eq ? CHAIN_EQ_IN : 1'b1);
   assign CHAIN_CO = sum[LGT_DW];
   assign CHAIN_SO = sout;
   assign CHAIN_EQ_OUT = eq_now;

   always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         acc0_reg <= LGT_ACC_RESET;
         acc1_reg <= LGT_ACC_RESET;
         d0_reg <= LGT_ACC_RESET;
         d1_reg <= LGT_ACC_RESET;
         carry_reg <= 1'b0;
         sout_reg <= 1'b0;
         eq_reg <= LGT_COND_RESET;
         zero_reg <= LGT_COND_RESET;
         ones_reg <= LGT_COND_RESET;
      end else begin
         if (DREG_WE && !DREG_SEL) d0_reg <= DREG_WDATA;
         if (DREG_WE && DREG_SEL) d1_reg <= DREG_WDATA;
         if (dp_run) begin
            if (cfg.acc_we && !cfg.reg_set) acc0_reg <= sh_val;
            if (cfg.acc_we && cfg.reg_set) acc1_reg <= sh_val;
            carry_reg <= sum[LGT_DW];
            sout_reg <= sout;
            eq_reg[cfg.reg_set] <= eq_now;
            zero_reg[cfg.reg_set] <= (sh_val == 8'h00);
            ones_reg[cfg.reg_set] <= (sh_val == 8'hff);
         end
      end
   end
   assign ACC0 = acc0_reg;
   assign ACC1 = acc1_reg;

   assign osrc = '{carry: carry_reg, sout: sout_reg, ones1: ones_reg[1], zero1: zero_reg[1],
                   eq1: eq_reg[1], ones0: ones_reg[0], zero0: zero_reg[0], eq0: eq_reg[0]};
   for (genvar i = 0; i < LGT_RT_N; i++) begin : g_rt_out
      assign rt_out_next[i] = osrc[OUT_SEL[i]];
   end

   // status sources: external routes, datapath outputs, pin inputs
   assign sts_src = {STS_RT_IN, rt_out_reg, PIN_RT_IN};
   for (genvar i = 0; i < LGT_STS_N; i++) begin : g_sts
      assign sts_live[i] = sts_src[STS_SEL[i]];
   end
   assign sts_set = sts_live & STS_STICKY & {LGT_STS_N{sc_run}};
   assign hold_next = sts_set | (hold_reg & ~{LGT_STS_N{STS_RD}});
   assign sts_view = (sts_live & ~STS_STICKY) | hold_reg | sts_set;

   always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rt_out_reg <= LGT_RT_RESET;
         ctl_reg <= LGT_CTL_RESET;
         hold_reg <= LGT_STS_RESET;
         sts_rdata_reg <= LGT_STS_RESET;
         drv_reg <= LGT_DRV_RESET;
      end else begin
         rt_out_reg <= rt_out_next;
         if (CTL_WE && sc_run) ctl_reg <= CTL_WDATA;
         hold_reg <= hold_next;
         if (STS_RD) sts_rdata_reg <= sts_view;
         drv_reg <= DRV_RT;
      end
   end
   assign RT_OUT = rt_out_reg;
   assign CTL_RT_OUT = ctl_reg & CTL_ROUTE_EN;
   assign STS_RDATA = sts_rdata_reg;
   assign PIN_DRV = drv_reg;

   for (genvar i = 0; i < LGT_PIN_N; i++) begin : g_pin
      lgt_pin_bit u_pin (
         .clk(SYS_CLK),
         .rst_n(rst_n_reg),
         .out_sync_en(PIN_CFG.out_sync[i]),
         .in_sync_en(PIN_CFG.in_sync[i]),
         .rt_out(PIN_RT_OUT[i]),
         .pin_in(PIN_IN[i]),
         .pin_out(PIN_OUT[i]),
         .rt_in(PIN_RT_IN[i])
      );
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!rst_n_reg);

   a_ctl_write: assert property (CTL_WE && sc_run |=> ctl_reg == $past(CTL_WDATA))
      else $error("control register missed a write");
   a_ctl_gated: assert property (CTL_WE && !sc_run |=> $stable(ctl_reg))
      else $error("control register written while unit disabled");
   a_read_data: assert property (STS_RD |=> STS_RDATA == $past(sts_view))
      else $error("status read returned wrong value");
   a_read_clear: assert property (STS_RD |=> (hold_reg & ~$past(sts_set)) == 8'h00)
      else $error("status read did not clear held bits");
   a_set_wins: assert property (|sts_set |=> (hold_reg & $past(sts_set)) == $past(sts_set))
      else $error("captured status lost");
   a_dp_gate: assert property (!dp_run |=> $stable(acc0_reg) && $stable(acc1_reg))
      else $error("accumulator changed while datapath disabled");
   a_carry_reg: assert property (dp_run |=> carry_reg == $past(sum[LGT_DW]))
      else $error("carry out not registered");
   a_acc_write: assert property (dp_run && cfg.acc_we && cfg.reg_set
      |=> acc1_reg == $past(sh_val))
      else $error("high half accumulator not written");
   a_rt_out: assert property (##1 RT_OUT == $past(rt_out_next))
      else $error("routed output not selected source");

   c_set_on_read: cover property (STS_RD && |sts_set);
   c_time_mux: cover property (dp_run && !cfg.reg_set ##1 dp_run && cfg.reg_set
      && cfg.cin_sel == LGT_CIN_REG);
   c_ctl_enable: cover property (DP_RUN_SEL == LGT_RUN_CTL && $rose(dp_run));
endmodule

// [tb/lgt_route_model.sv]
// routing fabric partner: drives the routed datapath inputs and the pin inputs
// assumes the bench changes addr, ce and pins just after a rising edge of the system clock
`timescale 1ns/1ns
module lgt_route_model
   import lgt_pkg::*;
(
   input wire logic [2:0] addr,
   input wire logic ce,
   input wire logic [7:0] pins,
   output lgt_rtin_s rt_in,
   output logic [7:0] pin_in
);
   // a valid selection stands on the routed inputs every cycle
   assign rt_in = '{ce: ce, cin: 1'b0, sin: 1'b0, cfg_addr: addr};
   assign pin_in = pins;
endmodule

// [tb/lgt_tile_test.sv]
// self-checking bench for lgt_tile: control, status, datapath and pin stage
// assumes lgt_pkg, lgt_tile and lgt_route_model are compiled first
`timescale 1ns/1ns
module lgt_tile_test
   import lgt_pkg::*;
;
   logic clk = 0, rst_n = 0, cfg_we = 0, dreg_we = 0, dreg_sel = 0, ctl_we = 0, sts_rd = 0;
   logic [2:0] cfg_waddr = 0, addr = 7, ce_sel = 0;
   lgt_cfg_s cfg_wdata = '0;
   logic [7:0] dreg_wdata = 0, ctl_wdata = 0, route_en = 8'hff, pins = 0, pin_rt_out = 0;
   logic [5:0][2:0] out_sel = '0;
   logic [7:0][3:0] sts_sel = {8{4'he}};
   logic [1:0] sts_rt_in = 0;
   logic [3:0] drv_rt = 0;
   lgt_run_e dp_run = LGT_RUN_OFF, sc_run = LGT_RUN_ALWAYS;
   lgt_pin_cfg_s pin_cfg = 16'h0101;
   lgt_rtin_s rt_in;
   logic [5:0] rt_out;
   logic [7:0] acc0, acc1, ctl_rt_out, sts_rdata, pin_in, pin_out, pin_rt_in;
   logic [3:0] pin_drv;
   logic chain_ci = 0, chain_si = 0, chain_eq_in = 1, sc_ext = 1, ce = 1;
   logic chain_co, chain_so, chain_eq_out;
   int n_fail = 0, cmp_count = 0, cyc = 0;

   always #2 clk = ~clk;

   lgt_route_model model_u (.addr(addr), .ce(ce), .pins(pins), .rt_in(rt_in),
      .pin_in(pin_in));

   lgt_tile dut_u (.SYS_CLK(clk), .RST_N(rst_n), .CFG_WE(cfg_we), .CFG_WADDR(cfg_waddr),
      .CFG_WDATA(cfg_wdata), .DREG_WE(dreg_we), .DREG_SEL(dreg_sel), .DREG_WDATA(dreg_wdata),
      .RT_IN(rt_in), .OUT_SEL(out_sel), .RT_OUT(rt_out), .ACC0(acc0), .ACC1(acc1),
      .CHAIN_CI(chain_ci), .CHAIN_SI(chain_si), .CHAIN_EQ_IN(chain_eq_in), .CHAIN_CO(chain_co),
      .CHAIN_SO(chain_so), .CHAIN_EQ_OUT(chain_eq_out), .DP_RUN_SEL(dp_run), .SC_RUN_SEL(sc_run),
      .CE_BIT_SEL(ce_sel), .SC_EXT_CE(sc_ext), .CTL_WE(ctl_we), .CTL_WDATA(ctl_wdata),
      .CTL_ROUTE_EN(route_en),
      .CTL_RT_OUT(ctl_rt_out), .STS_RT_IN(sts_rt_in), .STS_SEL(sts_sel),
      .STS_STICKY(8'h01), .STS_RD(sts_rd), .STS_RDATA(sts_rdata), .PIN_CFG(pin_cfg),
      .PIN_RT_OUT(pin_rt_out), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_RT_IN(pin_rt_in),
      .DRV_RT(drv_rt), .PIN_DRV(pin_drv));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         results();
      end
   end

   function automatic lgt_cfg_s cw(lgt_op_e op, logic set, lgt_cin_e cin, logic we);
      return '{spare: 4'h0, chain_eq: 1'b0, acc_we: we, sin_sel: LGT_SIN_ZERO,
         cin_sel: cin, reg_set: set, shift: LGT_SH_NONE, op: op};
   endfunction

   task automatic ctl_wr(input logic [7:0] d, input logic [7:0] exp);
      @(posedge clk) ctl_we <= 1;
      ctl_wdata <= d;
      @(posedge clk) ctl_we <= 0;
      #1 chk(ctl_rt_out, exp);
   endtask

   task automatic sts_read(input logic [7:0] exp);
      @(posedge clk) sts_rd <= 1;
      @(posedge clk) sts_rd <= 0;
      #1 chk(sts_rdata, exp);
   endtask

   task automatic t_reset();
      #1 chk(ctl_rt_out, 8'h00);
      chk(sts_rdata, 8'h00);
      chk(acc0, 8'h00);
      $display("reset test done");
   endtask

   task automatic t_control();
      @(posedge clk) route_en <= 8'hf0;
      ctl_wr(8'ha5, 8'ha0);
      @(posedge clk) sc_run <= LGT_RUN_CTL;
      ctl_wr(8'h5a, 8'h50);
      ctl_wr(8'hff, 8'h50);
      @(posedge clk) sc_run <= LGT_RUN_EXT;
      sc_ext <= 0;
      ctl_wr(8'h00, 8'h50);
      @(posedge clk) sc_run <= LGT_RUN_ALWAYS;
      $display("control test done");
   endtask

   task automatic t_status();
      @(posedge clk) sts_rt_in <= 2'h1;
      @(posedge clk) sts_rt_in <= 2'h0;
      sts_read(8'h01);
      sts_read(8'h00);
      @(posedge clk) sts_rt_in <= 2'h1;
      sts_rd <= 1;
      @(posedge clk) sts_rt_in <= 2'h0;
      sts_rd <= 0;
      #1 chk(sts_rdata, 8'hff);
      sts_read(8'h01);
      sts_read(8'h00);
      $display("status test done");
   endtask

   task automatic t_datapath();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) cfg_we <= 1;
         cfg_waddr <= i[2:0];
         cfg_wdata <= (i == 0) ? cw(LGT_OP_ADD, 0, LGT_CIN_ZERO, 1) :
            (i == 1) ? cw(LGT_OP_ADD, 1, LGT_CIN_REG, 1) : cw(LGT_OP_PASS, 0, LGT_CIN_ZERO, 0);
      end
      @(posedge clk) cfg_we <= 0;
      dreg_we <= 1;
      dreg_wdata <= 8'hff;
      @(posedge clk) dreg_sel <= 1;
      dreg_wdata <= 8'h00;
      @(posedge clk) dreg_we <= 0;
      dp_run <= LGT_RUN_ALWAYS;
      @(posedge clk) addr <= 0;
      @(posedge clk);
      @(posedge clk) addr <= 1;
      @(posedge clk) addr <= 7;
      #1 chk(acc0, 8'hfe);
      chk(acc1, 8'h01);
      $display("datapath test done");
   endtask

   // high set: a = acc1 = 01, d1 = 01; subtract with chain carry, shift left from chain
   task automatic t_chain();
      @(posedge clk) cfg_we <= 1;
      cfg_waddr <= 3'h2;
      cfg_wdata <= '{spare: 4'h0, chain_eq: 1'b1, acc_we: 1'b1, sin_sel: LGT_SIN_CHAIN,
         cin_sel: LGT_CIN_CHAIN, reg_set: 1'b1, shift: LGT_SH_LEFT, op: LGT_OP_SUB};
      dreg_we <= 1;
      dreg_wdata <= 8'h01;
      dp_run <= LGT_RUN_CTL;
      addr <= 3'h2;
      @(posedge clk) cfg_we <= 0;
      dreg_we <= 0;
      chain_si <= 1;
      #1 chk({5'h00, chain_co, chain_so, chain_eq_out}, 8'h03);
      @(posedge clk) chain_ci <= 1;
      chain_si <= 0;
      chain_eq_in <= 0;
      #1 chk({5'h00, chain_co, chain_so, chain_eq_out}, 8'h04);
      chk(acc1, 8'h01);
      @(posedge clk) ce_sel <= 3'h1;
      out_sel <= {3'h7, 3'h6, 3'h4, 3'h5, 3'h3, 3'h0};
      @(posedge clk) dp_run <= LGT_RUN_EXT;
      ce <= 0;
      #1 chk(acc1, 8'h00);
      @(posedge clk) ce <= 1;
      #1 chk({2'b00, rt_out}, 8'h28);
      chk(acc1, 8'h00);
      @(posedge clk) addr <= 3'h7;
      #1 chk(acc1, 8'hfe);
      $display("chain test done");
   endtask

   task automatic t_pins();
      @(posedge clk) pins <= 8'h03;
      pin_rt_out <= 8'h03;
      drv_rt <= 4'h9;
      #1 chk(pin_rt_in, 8'h02);
      chk(pin_out, 8'h02);
      @(posedge clk) #1 chk(pin_out, 8'h03);
      chk(pin_rt_in, 8'h02);
      chk({4'h0, pin_drv}, 8'h09);
      @(posedge clk) #1 chk(pin_rt_in, 8'h03);
      $display("pin test done");
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      t_reset();
      t_control();
      t_status();
      t_datapath();
      t_chain();
      t_pins();
      results();
   end
endmodule
